// ---- inc/pwm_pkg.sv ----
// Constants, types and register layout of the dual-slope PWM timer.
// Function
// - Phase correct: match while up acts one way, while down the opposite.
// - Waveform reaches the pin only while its direction bit selects output.
// - Timer clock divides the clock by 1, 8, 64, 256 or 1024.
// - Compare at BOTTOM holds low, at TOP holds high; inverted is opposite.
// - Mode 0xB with channel A action 0x1 toggles channel A at 50% duty.
// - Modes 0x8 and 0x9 count from 0x0000 up to TOP and back down.
// - Frequency correct non-inverting clears on up match, sets on down match.
// - TOP is capture in mode 0x8, compare A in 0x9; TOP reverses direction.
// - The count holds TOP for exactly one timer clock before decrementing.
// - Every compare match sets that channel's compare flag.
// - Active compare loads from a buffer; the modes differ in load moment.
// - Channel B compare low byte is read-write at 0x8A, reset zero.
// - High byte goes to the latch; low-byte write loads both together.
// - Count and capture low-byte reads copy the high byte to the latch for the next read.
`default_nettype none
package pwm_pkg;
    localparam logic [7:0] CTRL_A_ADDR = 8'h80;
    localparam logic [7:0] CTRL_B_ADDR = 8'h81;
    localparam logic [7:0] PIN_DIR_ADDR = 8'h82;
    localparam logic [7:0] FLAGS_ADDR = 8'h83;
    localparam logic [7:0] COUNT_L_ADDR = 8'h84;
    localparam logic [7:0] COUNT_H_ADDR = 8'h85;
    localparam logic [7:0] CAPTURE_L_ADDR = 8'h86;
    localparam logic [7:0] CAPTURE_H_ADDR = 8'h87;
    localparam logic [7:0] COMPARE_A_L_ADDR = 8'h88;
    localparam logic [7:0] COMPARE_A_H_ADDR = 8'h89;
    localparam logic [7:0] COMPARE_B_L_ADDR = 8'h8A;
    localparam logic [7:0] COMPARE_B_H_ADDR = 8'h8B;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] MAX_COUNT = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    // Field positions.
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int FLAG_A_BIT = 1;
    localparam int FLAG_B_BIT = 2;
    localparam int DIR_A_BIT = 0;
    localparam int DIR_B_BIT = 1;
    localparam int PRESCALE_WIDTH = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    typedef enum logic [3:0] {
        MODE_PC8 = 4'b0001,
        MODE_PC9 = 4'b0010,
        MODE_PC10 = 4'b0011,
        MODE_PFC_CAP = 4'b1000,
        MODE_PFC_CMPA = 4'b1001,
        MODE_PC_CAP = 4'b1010,
        MODE_PC_CMPA = 4'b1011
    } mode_t;

    typedef enum logic [2:0] {
        CLK_STOP = 3'b000,
        CLK_DIV1 = 3'b001,
        CLK_DIV8 = 3'b010,
        CLK_DIV64 = 3'b011,
        CLK_DIV256 = 3'b100,
        CLK_DIV1024 = 3'b101
    } clk_sel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic waveA;
        logic enA;
        logic waveB;
        logic enB;
    } pin_out_t;
endpackage : pwm_pkg
`default_nettype wire

// ---- logic/timer_prescaler.sv ----
// Prescaler that turns the clock into a one-cycle timer clock tick.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [2:0] clkSel,
    output logic tick
);
    logic [pwm_pkg::PRESCALE_WIDTH-1:0] div;
    logic [pwm_pkg::PRESCALE_WIDTH-1:0] next_div;
    logic [pwm_pkg::PRESCALE_WIDTH-1:0] mask;

    always_comb begin
        next_div = div + 10'h001;
        mask = '0;
        tick = 1'b0;
        case (clkSel)
            pwm_pkg::CLK_DIV1: tick = 1'b1;
            pwm_pkg::CLK_DIV8: mask = pwm_pkg::DIV8_MASK;
            pwm_pkg::CLK_DIV64: mask = pwm_pkg::DIV64_MASK;
            pwm_pkg::CLK_DIV256: mask = pwm_pkg::DIV256_MASK;
            pwm_pkg::CLK_DIV1024: mask = pwm_pkg::DIV1024_MASK;
            default: mask = '0;
        endcase
        if (mask != '0) begin
            tick = ((div & mask) == mask);
        end
        if (clkSel == pwm_pkg::CLK_STOP) begin
            tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div <= '0;
        end else if (ce) begin
            div <= next_div;
        end
    end
endmodule : timer_prescaler
`default_nettype wire

// ---- logic/dual_slope_pwm_timer.sv ----
// Dual-slope PWM timer with byte register port and two compare outputs.
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire pwm_pkg::bus_req_t busReq,
    output logic [7:0] rdata,
    output pwm_pkg::pin_out_t pins,
    output logic [1:0] compareFlags
);
    logic tick;
    logic [7:0] ctrlA, ctrlB, pinDir, latchHigh;
    logic [15:0] count, capture, cmpA, cmpB, bufA, bufB;
    logic up, levelA, levelB, flagA, flagB;
    logic [7:0] next_ctrlA, next_ctrlB, next_pinDir, next_latchHigh;
    logic [15:0] next_count, next_capture, next_cmpA, next_cmpB;
    logic [15:0] next_bufA, next_bufB;
    logic next_up, next_levelA, next_levelB, next_flagA, next_flagB;
    logic [7:0] next_rdata;
    pwm_pkg::pin_out_t next_pins;
    logic [3:0] mode;
    logic [15:0] top;
    logic [1:0] actA, actB;
    logic pfc, topIsCmpA, matchA, matchB, atTop, atBottom, wr, rd;

    timer_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .clkSel(ctrlB[2:0]),
        .tick(tick)
    );

    // One compare action on a tick; returns the new compare output state.
    function automatic logic waveStep(input logic level, input logic [1:0] act,
            input logic match, input logic upDir, input logic toggleOk);
        logic res;
        res = level;
        if (match) begin
            case (act)
                2'b01: res = toggleOk ? ~level : level;
                2'b10: res = ~upDir;
                2'b11: res = upDir;
                default: res = level;
            endcase
        end
        return res;
    endfunction : waveStep

    // Fixed levels at the extreme compare values override the slopes.
    function automatic logic waveLevel(input logic level,
            input logic [1:0] act, input logic [15:0] cmp,
            input logic [15:0] topVal);
        logic res;
        res = level;
        if (act[1] && cmp == pwm_pkg::BOTTOM) begin
            res = act[0];
        end else if (act[1] && cmp >= topVal) begin
            res = ~act[0];
        end
        return res;
    endfunction : waveLevel

    always_comb begin
        mode = {ctrlB[4:3], ctrlA[1:0]};
        actA = ctrlA[pwm_pkg::ACT_A_LSB +: 2];
        actB = ctrlA[pwm_pkg::ACT_B_LSB +: 2];
        pfc = (mode == pwm_pkg::MODE_PFC_CAP) ||
              (mode == pwm_pkg::MODE_PFC_CMPA);
        topIsCmpA = (mode == pwm_pkg::MODE_PFC_CMPA) ||
                    (mode == pwm_pkg::MODE_PC_CMPA);
        case (mode)
            pwm_pkg::MODE_PC8: top = pwm_pkg::TOP_8BIT;
            pwm_pkg::MODE_PC9: top = pwm_pkg::TOP_9BIT;
            pwm_pkg::MODE_PC10: top = pwm_pkg::TOP_10BIT;
            pwm_pkg::MODE_PFC_CAP: top = capture;
            pwm_pkg::MODE_PC_CAP: top = capture;
            pwm_pkg::MODE_PFC_CMPA: top = cmpA;
            pwm_pkg::MODE_PC_CMPA: top = cmpA;
            default: top = pwm_pkg::MAX_COUNT;
        endcase
        atTop = (count >= top);
        atBottom = (count == pwm_pkg::BOTTOM);
        matchA = tick && (count == cmpA);
        matchB = tick && (count == cmpB);
        wr = busReq.wr;
        rd = busReq.rd;
    end

    // Counter, compare registers and output state.
    always_comb begin
        next_count = count;
        next_up = up;
        next_cmpA = cmpA;
        next_cmpB = cmpB;
        next_levelA = levelA;
        next_levelB = levelB;
        next_flagA = flagA;
        next_flagB = flagB;
        if (tick) begin
            if (up && atTop) begin
                next_up = 1'b0;
                next_count = count - 16'h0001;
            end else if (!up && atBottom) begin
                next_up = 1'b1;
                next_count = count + 16'h0001;
            end else if (up) begin
                next_count = count + 16'h0001;
            end else begin
                next_count = count - 16'h0001;
            end
            if ((pfc && atBottom) || (!pfc && up && atTop)) begin
                next_cmpA = bufA;
                next_cmpB = bufB;
            end
        end
        next_levelA = waveStep(levelA, actA, matchA, up, topIsCmpA);
        next_levelB = waveStep(levelB, actB, matchB, up, 1'b0);
        if (tick) begin
            next_levelA = waveLevel(next_levelA, actA, cmpA, top);
            next_levelB = waveLevel(next_levelB, actB, cmpB, top);
        end
        if (wr && busReq.addr == pwm_pkg::FLAGS_ADDR) begin
            if (busReq.wdata[pwm_pkg::FLAG_A_BIT]) next_flagA = 1'b0;
            if (busReq.wdata[pwm_pkg::FLAG_B_BIT]) next_flagB = 1'b0;
        end
        // A match in the clearing cycle keeps its flag.
        if (matchA) next_flagA = 1'b1;
        if (matchB) next_flagB = 1'b1;
        if (wr && busReq.addr == pwm_pkg::COUNT_L_ADDR) begin
            next_count = {latchHigh, busReq.wdata};
        end
    end

    // Register port: writes, the shared high-byte latch and read data.
    always_comb begin
        next_ctrlA = ctrlA;
        next_ctrlB = ctrlB;
        next_pinDir = pinDir;
        next_latchHigh = latchHigh;
        next_capture = capture;
        next_bufA = bufA;
        next_bufB = bufB;
        next_rdata = rdata;
        if (wr) begin
            case (busReq.addr)
                pwm_pkg::CTRL_A_ADDR: next_ctrlA = busReq.wdata;
                pwm_pkg::CTRL_B_ADDR: next_ctrlB = busReq.wdata;
                pwm_pkg::PIN_DIR_ADDR: next_pinDir = busReq.wdata;
                pwm_pkg::COUNT_H_ADDR,
                pwm_pkg::CAPTURE_H_ADDR,
                pwm_pkg::COMPARE_A_H_ADDR,
                pwm_pkg::COMPARE_B_H_ADDR:
                    next_latchHigh = busReq.wdata;
                pwm_pkg::CAPTURE_L_ADDR:
                    next_capture = {latchHigh, busReq.wdata};
                pwm_pkg::COMPARE_A_L_ADDR:
                    next_bufA = {latchHigh, busReq.wdata};
                pwm_pkg::COMPARE_B_L_ADDR:
                    next_bufB = {latchHigh, busReq.wdata};
                default: next_latchHigh = latchHigh;
            endcase
        end else if (rd) begin
            case (busReq.addr)
                pwm_pkg::CTRL_A_ADDR: next_rdata = ctrlA;
                pwm_pkg::CTRL_B_ADDR: next_rdata = ctrlB;
                pwm_pkg::PIN_DIR_ADDR: next_rdata = pinDir;
                pwm_pkg::FLAGS_ADDR: begin
                    next_rdata = pwm_pkg::BYTE_RESET;
                    next_rdata[pwm_pkg::FLAG_A_BIT] = flagA;
                    next_rdata[pwm_pkg::FLAG_B_BIT] = flagB;
                end
                pwm_pkg::COUNT_L_ADDR: begin
                    next_rdata = count[7:0];
                    next_latchHigh = count[15:8];
                end
                pwm_pkg::CAPTURE_L_ADDR: begin
                    next_rdata = capture[7:0];
                    next_latchHigh = capture[15:8];
                end
                pwm_pkg::COUNT_H_ADDR,
                pwm_pkg::CAPTURE_H_ADDR: next_rdata = latchHigh;
                // Compare reads bypass the latch and show the buffered value.
                pwm_pkg::COMPARE_A_L_ADDR: next_rdata = bufA[7:0];
                pwm_pkg::COMPARE_A_H_ADDR: next_rdata = bufA[15:8];
                pwm_pkg::COMPARE_B_L_ADDR: next_rdata = bufB[7:0];
                pwm_pkg::COMPARE_B_H_ADDR: next_rdata = bufB[15:8];
                default: next_rdata = pwm_pkg::BYTE_RESET;
            endcase
        end
        next_pins.waveA = levelA;
        next_pins.waveB = levelB;
        // Without an action the pin falls back to input.
        next_pins.enA = pinDir[pwm_pkg::DIR_A_BIT] && (actA != 2'b00);
        next_pins.enB = pinDir[pwm_pkg::DIR_B_BIT] && (actB != 2'b00);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= pwm_pkg::WORD_RESET;
            capture <= pwm_pkg::WORD_RESET;
            cmpA <= pwm_pkg::WORD_RESET;
            cmpB <= pwm_pkg::WORD_RESET;
            bufA <= pwm_pkg::WORD_RESET;
            bufB <= pwm_pkg::WORD_RESET;
            levelA <= 1'b0;
            levelB <= 1'b0;
            up <= 1'b1;
            flagA <= 1'b0;
            flagB <= 1'b0;
            ctrlA <= pwm_pkg::BYTE_RESET;
            ctrlB <= pwm_pkg::BYTE_RESET;
            pinDir <= pwm_pkg::BYTE_RESET;
            latchHigh <= pwm_pkg::BYTE_RESET;
            rdata <= pwm_pkg::BYTE_RESET;
            pins <= '0;
            compareFlags <= 2'b00;
        end else if (ce) begin
            count <= next_count;
            capture <= next_capture;
            cmpA <= next_cmpA;
            cmpB <= next_cmpB;
            bufA <= next_bufA;
            bufB <= next_bufB;
            levelA <= next_levelA;
            levelB <= next_levelB;
            up <= next_up;
            flagA <= next_flagA;
            flagB <= next_flagB;
            ctrlA <= next_ctrlA;
            ctrlB <= next_ctrlB;
            pinDir <= next_pinDir;
            latchHigh <= next_latchHigh;
            rdata <= next_rdata;
            pins <= next_pins;
            compareFlags <= {next_flagB, next_flagA};
        end
    end
endmodule : dual_slope_pwm_timer
`default_nettype wire

// ---- bench/pwm_timer_asserts.sv ----
// Port checker for the dual-slope PWM timer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire pwm_pkg::bus_req_t busReq,
    input wire logic [7:0] rdata,
    input wire pwm_pkg::pin_out_t pins,
    input wire logic [1:0] compareFlags
);
    logic [1:0] actA;
    logic [1:0] dir;
    logic [7:0] bLow;
    logic stop;
    logic [1:0] idle;
    logic wrOk;
    logic clrA;
    assign wrOk = ce && busReq.wr;
    assign clrA = wrOk && busReq.addr == pwm_pkg::FLAGS_ADDR
        && busReq.wdata[1];
    // Shadows follow accepted writes only, as the block's registers do.
    always_ff @(posedge clk) begin
        if (rst && ce) begin
            actA <= 2'h0;
            dir <= 2'h0;
            bLow <= 8'h00;
            stop <= 1'b1;
        end else if (wrOk) begin
            if (busReq.addr == pwm_pkg::CTRL_A_ADDR) actA <= busReq.wdata[7:6];
            if (busReq.addr == pwm_pkg::PIN_DIR_ADDR) dir <= busReq.wdata[1:0];
            if (busReq.addr == 8'h8A) bLow <= busReq.wdata;
            if (busReq.addr == pwm_pkg::CTRL_B_ADDR)
                stop <= !(|busReq.wdata[2:0]);
        end
    end
    // Quiet cycles let a tick already in the pipeline land before freezing.
    always_ff @(posedge clk) begin
        if (rst || busReq.wr || !stop) idle <= 2'h0;
        else if (idle != 2'h3) idle <= idle + 2'h1;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_reset_clears: assert property (disable iff (1'b0)
        rst && ce |=> rdata == 8'h00 && pins == 4'h0 && compareFlags == 2'h0)
        else $error("Outputs not cleared by reset.");
    a_dir_off: assert property (
        wrOk && busReq.addr == pwm_pkg::PIN_DIR_ADDR && !busReq.wdata[0]
        |-> ##2 !pins.enA) else $error("Channel A driven with pin as input.");
    a_dir_on: assert property (
        wrOk && busReq.addr == pwm_pkg::PIN_DIR_ADDR && busReq.wdata[0]
        && actA != 2'h0 |-> ##2 pins.enA) else $error("Channel A not driven.");
    a_no_dir_b: assert property (
        !dir[1] && !$past(dir[1]) |-> !pins.enB)
        else $error("Channel B driven with pin as input.");
    a_low_b_read: assert property (
        ce && busReq.rd && !busReq.wr && busReq.addr == 8'h8A
        |=> rdata == bLow) else $error("Compare B low byte read wrong.");
    a_read_holds: assert property (
        !(ce && busReq.rd && !busReq.wr) |=> $stable(rdata))
        else $error("Read data changed without a read.");
    a_flag_sticky: assert property (
        compareFlags[0] && !clrA && !$past(clrA) |=> compareFlags[0])
        else $error("Compare flag A dropped without a clear.");
    a_stop_freeze: assert property (
        idle == 2'h3 && !busReq.wr |=> $stable(pins) && $stable(compareFlags))
        else $error("Outputs moved with the timer clock stopped.");
endmodule : pwm_timer_checker
bind dual_slope_pwm_timer pwm_timer_checker u_pwm_timer_checker (
    .clk(clk), .rst(rst), .ce(ce), .busReq(busReq), .rdata(rdata),
    .pins(pins), .compareFlags(compareFlags));
`default_nettype wire

// ---- bench/pwm_pin_load.sv ----
// Load on the two compare output pins, each line with a pull-down.
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_load (
    input wire pwm_pkg::pin_out_t pins,
    output logic levelA,
    output logic levelB
);
    // A released pin falls low, so a stale level can never pass as driven.
    assign levelA = pins.enA ? pins.waveA : 1'b0;
    assign levelB = pins.enB ? pins.waveB : 1'b0;
endmodule : pwm_pin_load
`default_nettype wire

// ---- bench/tb_dual_slope_pwm_timer.sv ----
// Self-checking bench for the dual-slope PWM timer.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_slope_pwm_timer;
    localparam int DIVS [6] = '{0, 1, 8, 64, 256, 1024};
    // Rows: mode, action B, TOP, compare B, high ticks, low ticks.
    localparam logic [31:0] ROWS [5] = '{32'h9_2_03_01_2_4,
        32'h9_3_03_01_4_2, 32'h8_2_05_01_2_8, 32'hB_2_03_01_2_4,
        32'hA_3_05_02_6_4};
    logic clk;
    logic rst = 1'b1;
    logic ce = 1'b1;
    pwm_pkg::bus_req_t busReq = '0;
    logic [7:0] rdata;
    pwm_pkg::pin_out_t pins;
    logic [1:0] compareFlags;
    logic levelA;
    logic levelB;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int hi;
    int lo;
    dual_slope_pwm_timer u_dual_slope_pwm_timer (.clk(clk), .rst(rst),
        .ce(ce), .busReq(busReq), .rdata(rdata), .pins(pins),
        .compareFlags(compareFlags));
    pwm_pin_load u_pwm_pin_load (.pins(pins), .levelA(levelA),
        .levelB(levelB));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq.addr = a;
        busReq.wdata = d;
        busReq.wr = 1'b1;
        step();
        busReq.wr = 1'b0;
        step();
    endtask : wr
    // Nothing may touch the shared latch between the two halves.
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a + 8'h01, d[15:8]);
        wr(a, d[7:0]);
    endtask : wr16
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        busReq.addr = a;
        busReq.rd = 1'b1;
        step();
        busReq.rd = 1'b0;
        chk({8'h00, rdata}, {8'h00, exp});
        step();
    endtask : rdchk
    task automatic cfg(input logic [3:0] m, input logic [1:0] aa,
            input logic [1:0] ab, input logic [15:0] top,
            input logic [15:0] cb, input logic [2:0] sel);
        wr(8'h81, {3'h0, m[3:2], 3'h0});
        wr(8'h80, {aa, ab, 2'h0, m[1:0]});
        wr16(8'h86, top);
        wr16(8'h88, m[0] ? top : 16'h0009);
        wr16(8'h8A, cb);
        // A start at one lets a stale active TOP of zero turn back at once.
        wr16(8'h84, 16'h0001);
        wr(8'h82, 8'h03);
        wr(8'h81, {3'h0, m[3:2], sel});
    endtask : cfg
    task automatic waitLv(input logic ch, input logic v, output int n);
        n = 0;
        while ((ch ? levelA : levelB) !== v && n < 7000) begin
            step();
            n++;
        end
    endtask : waitLv
    // The first period after a change is skipped, as buffers load late.
    task automatic measure(input logic ch);
        int n;
        waitLv(ch, 1'b1, n);
        waitLv(ch, 1'b0, n);
        waitLv(ch, 1'b1, lo);
        waitLv(ch, 1'b0, hi);
    endtask : measure
    task automatic s_regs();
        rdchk(8'h8A, 8'h00);
        rdchk(8'h84, 8'h00);
        wr16(8'h8A, 16'h1234);
        rdchk(8'h8A, 8'h34);
        rdchk(8'h8B, 8'h12);
        wr16(8'h84, 16'h01FF);
        wr(8'h89, 8'hA5);
        rdchk(8'h84, 8'hFF);
        rdchk(8'h85, 8'h01);
        rdchk(8'h90, 8'h00);
    endtask : s_regs
    task automatic s_shapes();
        for (int i = 0; i < 5; i++) begin
            cfg(ROWS[i][31:28], 2'h0, ROWS[i][25:24],
                {8'h00, ROWS[i][23:16]}, {8'h00, ROWS[i][15:8]}, 3'h1);
            measure(1'b0);
            chk(16'(hi), {12'h000, ROWS[i][7:4]});
            chk(16'(lo), {12'h000, ROWS[i][3:0]});
        end
    endtask : s_shapes
    task automatic s_prescale();
        for (int s = 1; s < 6; s++) begin
            cfg(4'h9, 2'h0, 2'h2, 16'h0003, 16'h0001, 3'(s));
            measure(1'b0);
            chk(16'(hi), 16'(2 * DIVS[s]));
            chk(16'(lo), 16'(4 * DIVS[s]));
        end
    endtask : s_prescale
    task automatic s_toggle();
        cfg(4'hB, 2'h1, 2'h0, 16'h0003, 16'h0001, 3'h1);
        measure(1'b1);
        chk(16'(hi), 16'h0006);
        chk(16'(lo), 16'h0006);
    endtask : s_toggle
    task automatic s_limits();
        int bad;
        for (int k = 0; k < 4; k++) begin
            cfg(4'h9, 2'h0, {1'b1, ~k[0]}, 16'h0003,
                k[1] ? 16'h0003 : 16'h0000, 3'h1);
            repeat (16) step();
            bad = 0;
            repeat (24) begin
                step();
                if (levelB !== ~(k[1] ^ k[0])) bad++;
            end
            chk(16'(bad), 16'h0000);
        end
        wr(8'h82, 8'h00);
        repeat (3) step();
        chk({15'h0000, levelB}, 16'h0000);
    endtask : s_limits
    task automatic s_flags();
        cfg(4'h9, 2'h0, 2'h2, 16'h0003, 16'h0001, 3'h0);
        wr(8'h83, 8'h06);
        repeat (3) step();
        chk({14'h0000, compareFlags}, 16'h0000);
        wr(8'h81, 8'h11);
        repeat (12) step();
        wr(8'h81, 8'h10);
        repeat (4) step();
        chk({14'h0000, compareFlags}, 16'h0003);
    endtask : s_flags
    task automatic s_rerun();
        cfg(4'h9, 2'h1, 2'h2, 16'h0003, 16'h0003, 3'h1);
        repeat (20) step();
        rst = 1'b1;
        step();
        rst = 1'b0;
        chk({12'h000, pins}, 16'h0000);
        chk({14'h0000, compareFlags}, 16'h0000);
        rdchk(8'h8A, 8'h00);
        rdchk(8'h84, 8'h00);
    endtask : s_rerun
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        s_regs();
        s_shapes();
        s_prescale();
        s_toggle();
        s_limits();
        s_flags();
        s_rerun();
        test_done();
    end
endmodule : tb_dual_slope_pwm_timer
`default_nettype wire
